// file: design/synth_pkg.sv
// shared constants for the clock synthesizer digital block
package synth_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hC;
  // control field positions
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_EN_W = 6;
  localparam int CTRL_OSC_LSB = 6;
  localparam int CTRL_RATIO_LSB = 8;
  localparam int CTRL_MHI_BIT = 11;
  // control reset: all outputs enabled, internal oscillator, ratio 3
  localparam logic [11:0] CTRL_RST = 12'h37F;
  localparam logic [5:0] EN_RST = 6'h3F;
  // status bits
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_XOR_BIT = 1;
  localparam int ST_SINK_BIT = 2;
  localparam int ST_SOURCE_BIT = 3;
  // interrupt bits
  localparam int IRQ_GAIN_BIT = 0;
  localparam int IRQ_LOSS_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // oscillator source select codes
  localparam logic [1:0] OSC_EXT_HI = 2'h0;
  localparam logic [1:0] OSC_INT_622 = 2'h1;
  localparam logic [1:0] OSC_INT_1244 = 2'h2;
  localparam logic [1:0] OSC_EXT_DIRECT = 2'h3;
  // ratio code with no divide: disable or feedback
  localparam logic [2:0] RATIO_SPECIAL = 3'h7;
  // lock filter
  localparam int LOCK_ACC_W = 8;
  localparam logic [7:0] LOCK_ACC_MAX = 8'hFF;
  localparam logic [7:0] LOCK_THRESH = 8'h40;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : synth_pkg

// file: design/clk_out_gate.sv
// glitch-free enable gate for one output clock, on the falling edge
`timescale 1ns/1ps
module clk_out_gate
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // divider level about to be taken, and enable request
  input wire logic level_i,
  input wire logic enable_i,
  // gated clock
  output logic clk_o
);
  logic en_ff;

  always_ff @(negedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      en_ff <= 1'b1;
      clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // enable only moves in a low phase, so no pulse is ever cut short
      if (!level_i)
        en_ff <= enable_i;
      clk_o <= level_i & en_ff;
    end
  end
endmodule : clk_out_gate

// file: design/synth_divider_lock_detect.sv
// clock synthesizer digital side: dividers, output gates, lock detect, phase detector
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module synth_divider_lock_detect
(
  // clock, reset, clock enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // reference clock, sampled as synchronous
  input wire logic ref_clk_i,
  // output clocks
  output logic master_out_a_o,
  output logic master_out_b_o,
  output logic half_rate_out_o,
  output logic quarter_rate_out_o,
  output logic eighth_rate_out_o,
  output logic sixteenth_rate_out_o,
  // lock detect and pump
  output logic raw_lock_xor_o,
  output logic lock_status_out_o,
  output logic pump_output_sink_o,
  output logic pump_output_source_o,
  output logic irq_o,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [11:0] ctrl_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [3:0] awaddr_ff;
  logic aw_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_got_ff;
  logic [1:0] pre_cnt_ff;
  logic [6:0] div_ff;
  logic ref_ff;
  logic fb_ff;
  logic up_ff;
  logic dn_ff;
  logic [7:0] lock_acc_ff;
  logic locked_d_ff;

  // control fields
  wire [5:0] en_w = ctrl_ff[synth_pkg::CTRL_EN_LSB +: synth_pkg::CTRL_EN_W];
  wire [1:0] osc_sel_w = ctrl_ff[synth_pkg::CTRL_OSC_LSB +: 2];
  wire [2:0] ratio_w = ctrl_ff[synth_pkg::CTRL_RATIO_LSB +: 3];
  wire master_hi_w = ctrl_ff[synth_pkg::CTRL_MHI_BIT];

  // oscillator to master prescale: internal needs /4 or /2, external /2 or /1
  wire [1:0] pre_max_w = (osc_sel_w == synth_pkg::OSC_INT_622) ? 2'h3 :
                         (osc_sel_w == synth_pkg::OSC_EXT_DIRECT) ? 2'h0 : 2'h1;
  wire master_tick_w = (pre_cnt_ff == pre_max_w);
  wire [1:0] nxt_pre_cnt = master_tick_w ? 2'h0 : pre_cnt_ff + 2'h1;
  wire [6:0] nxt_div = master_tick_w ? div_ff + 7'h01 : div_ff;

  // one shared counter on the falling edge keeps every output phase-aligned
  always_ff @(negedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_cnt_ff <= 2'h0;
      div_ff <= 7'h00;
    end
    else if (ce_i)
    begin
      pre_cnt_ff <= nxt_pre_cnt;
      div_ff <= nxt_div;
    end
  end

  // output tap per gate: a, b undivided, then /2 ... /16
  wire [5:0] level_w = {nxt_div[4], nxt_div[3], nxt_div[2], nxt_div[1], nxt_div[0], nxt_div[0]};
  wire [5:0] gated_w;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_out
      clk_out_gate u_gate
      (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .level_i(level_w[gi]),
        .enable_i(en_w[gi]),
        .clk_o(gated_w[gi])
      );
    end
  endgenerate
  assign master_out_a_o = gated_w[0];
  assign master_out_b_o = gated_w[1];
  assign half_rate_out_o = gated_w[2];
  assign quarter_rate_out_o = gated_w[3];
  assign eighth_rate_out_o = gated_w[4];
  assign sixteenth_rate_out_o = gated_w[5];

  // feedback tap from the same counter, so a locked output at reference rate rises with it
  wire fb_w = (ratio_w == synth_pkg::RATIO_SPECIAL) ? (master_hi_w & div_ff[0]) : div_ff[ratio_w];

  // phase/frequency detector on rising edges
  wire ref_rise_w = ref_clk_i & ~ref_ff;
  wire fb_rise_w = fb_w & ~fb_ff;
  wire nxt_up = (up_ff | ref_rise_w) & ~((up_ff | ref_rise_w) & (dn_ff | fb_rise_w));
  wire nxt_dn = (dn_ff | fb_rise_w) & ~((up_ff | ref_rise_w) & (dn_ff | fb_rise_w));
  wire xor_w = ref_clk_i ^ fb_w;

  // lock filter: saturating integrator stands in for the external capacitor
  wire [7:0] nxt_acc = xor_w ? ((lock_acc_ff == synth_pkg::LOCK_ACC_MAX) ? lock_acc_ff : lock_acc_ff + 8'h01) :
                               ((lock_acc_ff == 8'h00) ? lock_acc_ff : lock_acc_ff - 8'h01);
  wire locked_w = (lock_acc_ff < synth_pkg::LOCK_THRESH);

  // detector and filter state
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ref_ff <= 1'b0;
      fb_ff <= 1'b0;
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
      lock_acc_ff <= synth_pkg::LOCK_ACC_MAX;
      locked_d_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      ref_ff <= ref_clk_i;
      fb_ff <= fb_w;
      up_ff <= nxt_up;
      dn_ff <= nxt_dn;
      lock_acc_ff <= nxt_acc;
      locked_d_ff <= locked_w;
    end
  end

  // lock and pump outputs leave flip-flops of their own
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      raw_lock_xor_o <= 1'b0;
      lock_status_out_o <= 1'b0;
      pump_output_sink_o <= 1'b0;
      pump_output_source_o <= 1'b0;
    end
    else if (ce_i)
    begin
      raw_lock_xor_o <= xor_w;
      lock_status_out_o <= locked_w;
      pump_output_sink_o <= nxt_up;
      pump_output_source_o <= nxt_dn;
    end
  end

  // interrupt events
  wire gain_w = locked_w & ~locked_d_ff;
  wire loss_w = ~locked_w & locked_d_ff;

  // register bus decode
  wire wr_go_w = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_ctrl_w = wr_go_w & (awaddr_ff == synth_pkg::CTRL_OFS);
  wire wr_stat_w = wr_go_w & (awaddr_ff == synth_pkg::IRQ_STAT_OFS);
  wire wr_mask_w = wr_go_w & (awaddr_ff == synth_pkg::IRQ_MASK_OFS);
  wire wr_ok_w = wr_ctrl_w | wr_stat_w | wr_mask_w | (awaddr_ff == synth_pkg::STATUS_OFS);
  wire [11:0] ctrl_mask_w = {{4{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [11:0] nxt_ctrl = (ctrl_ff & ~ctrl_mask_w) | (wdata_ff[11:0] & ctrl_mask_w);
  wire [1:0] w1c_w = (wr_stat_w & wstrb_ff[0]) ? wdata_ff[1:0] : 2'h0;
  // a new event wins over a clear in the same cycle
  wire [1:0] nxt_irq_stat = (irq_stat_ff & ~w1c_w) | {loss_w, gain_w};
  wire [3:0] status_w = {pump_output_source_o, pump_output_sink_o, raw_lock_xor_o, lock_status_out_o};
  wire [31:0] rd_ctrl_w = {20'h00000, ctrl_ff};
  wire [31:0] rd_status_w = {28'h0000000, status_w};
  wire [31:0] rd_irq_stat_w = {30'h0, irq_stat_ff};
  wire [31:0] rd_irq_mask_w = {30'h0, irq_mask_ff};
  wire [31:0] rd_data_w = (s_axi_araddr == synth_pkg::CTRL_OFS) ? rd_ctrl_w :
                          (s_axi_araddr == synth_pkg::STATUS_OFS) ? rd_status_w :
                          (s_axi_araddr == synth_pkg::IRQ_STAT_OFS) ? rd_irq_stat_w :
                          rd_irq_mask_w;
  wire rd_ok_w = (s_axi_araddr[1:0] == 2'h0);

  // write channel: address and data may arrive in either order
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      awaddr_ff <= 4'h0;
      aw_got_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      w_got_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= synth_pkg::RESP_OKAY;
    end
    else if (ce_i)
    begin
      s_axi_awready <= ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_got_ff & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        awaddr_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_got_ff <= 1'b1;
      end
      if (wr_go_w)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok_w ? synth_pkg::RESP_OKAY : synth_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and interrupt registers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_ff <= synth_pkg::CTRL_RST;
      irq_stat_ff <= synth_pkg::IRQ_RST;
      irq_mask_ff <= synth_pkg::IRQ_RST;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl_w)
      begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_mask_w & wstrb_ff[0])
      begin
        irq_mask_ff <= wdata_ff[1:0];
      end
      irq_stat_ff <= nxt_irq_stat;
      irq_o <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // read channel: data is captured with the address, so it stands until taken
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= synth_pkg::RESP_OKAY;
    end
    else if (ce_i)
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok_w ? rd_data_w : 32'h00000000;
        s_axi_rresp <= rd_ok_w ? synth_pkg::RESP_OKAY : synth_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : synth_divider_lock_detect

// file: tb/ref_src_model.sv
// reference clock source model facing the synthesizer
`timescale 1ns/1ps
module ref_src_model
(
  // clock
  input wire logic clk_i,
  // requested reference level
  input wire logic level_i,
  // reference clock to the block
  output logic ref_clk_o
);
  // a held level stands for a reference that does not match the ratio
  initial ref_clk_o = 1'b0;
  always @(posedge clk_i)
    ref_clk_o <= level_i;
endmodule : ref_src_model

// file: tb/synth_divider_lock_detect_sva.sv
// concurrent checks on the synthesizer ports
`timescale 1ns/1ps
module synth_divider_lock_detect_sva
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // reference input
  input wire logic ref_clk_i,
  // watched outputs
  input wire logic master_out_a_o,
  input wire logic half_rate_out_o,
  input wire logic sixteenth_rate_out_o,
  input wire logic pump_output_sink_o,
  input wire logic pump_output_source_o,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // rising-edge snapshot; a change by the next falling edge means a rising launch
  logic [2:0] pcap_ff;
  always_ff @(posedge clk_i)
    pcap_ff <= {master_out_a_o, half_rate_out_o, sixteenth_rate_out_o};
  chk_fall_launch: assert property (@(negedge clk_i) disable iff (!arst_n_i)
    {master_out_a_o, half_rate_out_o, sixteenth_rate_out_o} == pcap_ff) else $error("output moved on rising edge");
  chk_sink_after_ref: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(pump_output_sink_o) |-> ($past(ref_clk_i) && !$past(ref_clk_i, 2)) || !$past(arst_n_i, 2))
    else $error("pump sink without reference edge");
  chk_aw_taken: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready held after take");
  chk_ar_taken: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##0 s_axi_rvalid) else $error("read not answered");
  chk_w_taken: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("wready held after take");
  chk_b_answer: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(s_axi_bvalid) |-> $past(s_axi_awready, 2) || $past(s_axi_wready, 2) || !$past(arst_n_i, 2))
    else $error("response without request");
  chk_b_stands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  chk_r_stands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("rvalid dropped");
endmodule : synth_divider_lock_detect_sva
bind synth_divider_lock_detect synth_divider_lock_detect_sva chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .ref_clk_i(ref_clk_i),
  .master_out_a_o(master_out_a_o), .half_rate_out_o(half_rate_out_o), .sixteenth_rate_out_o(sixteenth_rate_out_o),
  .pump_output_sink_o(pump_output_sink_o), .pump_output_source_o(pump_output_source_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: tb/tb_synth_divider_lock_detect.sv
// testbench for the synthesizer digital block
`timescale 1ns/1ps
module tb_synth_divider_lock_detect;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ref_level = 1'b0;
  logic ce = 1'b1;
  logic [5:0] frozen;
  logic ref_clk_i;
  logic [5:0] outs;
  logic raw_xor, lock_st, sink, source, irq_o;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0;
  int check_count = 0;
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  ref_src_model ref_u (.clk_i(clk_i), .level_i(ref_level), .ref_clk_o(ref_clk_i));
  synth_divider_lock_detect dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .ref_clk_i(ref_clk_i),
    .master_out_a_o(outs[0]), .master_out_b_o(outs[1]), .half_rate_out_o(outs[2]), .quarter_rate_out_o(outs[3]),
    .eighth_rate_out_o(outs[4]), .sixteenth_rate_out_o(outs[5]), .raw_lock_xor_o(raw_xor),
    .lock_status_out_o(lock_st), .pump_output_sink_o(sink), .pump_output_source_o(source), .irq_o(irq_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once taken; bready waits one cycle so the answer must stand
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(synth_pkg::RESP_OKAY));
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // 256 cycles hold whole periods of every tap, so rise counts are exact
  task automatic count_rises(input logic [5:0] en);
    int n[6];
    logic [5:0] prev;
    n = '{default: 0};
    repeat (40) @(posedge clk_i);
    prev = outs;
    repeat (256)
    begin
      @(posedge clk_i);
      for (int i = 0; i < 6; i++)
        n[i] += int'(outs[i] && !prev[i]);
      prev = outs;
    end
    for (int i = 0; i < 6; i++)
      chk(32'(n[i]), en[i] ? 32'(256 >> (i < 2 ? 1 : i)) : 32'h0);
  endtask : count_rises
  initial
  begin
    #50000;
    err_total++;
    end_sim;
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(synth_pkg::CTRL_OFS, 32'h37F, synth_pkg::RESP_OKAY);
    rd(synth_pkg::IRQ_MASK_OFS, 32'h0, synth_pkg::RESP_OKAY);
    rd(4'h2, 32'h0, synth_pkg::RESP_SLVERR);
    wr(synth_pkg::IRQ_MASK_OFS, 32'h1);
    // one clock per master tick, ratio code 7 with low row holds feedback at 0
    wr(synth_pkg::CTRL_OFS, 32'h7FF);
    count_rises(6'h3F);
    wr(synth_pkg::CTRL_OFS, 32'h7ED);
    count_rises(6'h2D);
    // a low clock enable freezes the dividers; an odd span would flip the master output if it ran
    ce <= 1'b0;
    @(posedge clk_i);
    frozen = outs;
    repeat (21) @(posedge clk_i);
    chk(32'(outs), 32'(frozen));
    ce <= 1'b1;
    rd(synth_pkg::CTRL_OFS, 32'h7ED, synth_pkg::RESP_OKAY);
    chk(32'({irq_o, lock_st, raw_xor}), 32'h6);
    rd(synth_pkg::STATUS_OFS, 32'h1, synth_pkg::RESP_OKAY);
    rd(synth_pkg::IRQ_STAT_OFS, 32'h1, synth_pkg::RESP_OKAY);
    wr(synth_pkg::IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    // a reference that never matches the feedback drops lock and calls for more speed
    ref_level <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk(32'({irq_o, lock_st, raw_xor}), 32'h1);
    rd(synth_pkg::STATUS_OFS, 32'h6, synth_pkg::RESP_OKAY);
    rd(synth_pkg::IRQ_STAT_OFS, 32'h2, synth_pkg::RESP_OKAY);
    wr(synth_pkg::IRQ_MASK_OFS, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    wr(synth_pkg::IRQ_STAT_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    end_sim;
  end
endmodule : tb_synth_divider_lock_detect
